// ===== logic/flash_cmd_pkg.sv
// Constants and types shared by the flash command sequencer.
// Assumes an asynchronous byte-mode parallel flash driven from clk_sys.
// How it works
// RULE_01 - Device latches address on later falling edge of strobe or select.
// RULE_02 - Device latches data on earlier rising edge of strobe or select.
// RULE_03 - All command cycles are writes except array read and autoselect read.
// RULE_04 - Upper data byte is ignored in command cycles.
// RULE_05 - Sector address bits are don't-care unless a cycle needs bank or sector.
// RULE_06 - Plain array read needs one read cycle, no unlock writes.
// RULE_07 - One F0 write to any address resets bank to read state.
// RULE_08 - Autoselect: AA@AAA, 55@555, 90@AAA in bank, then bank reads.
// RULE_09 - Device identifier read at bank offsets 02, 1C and 1E.
// RULE_10 - Autoselect read at X06 returns 80h locked, 00h unlocked.
// RULE_11 - Autoselect read at sector X04 returns 01h protected, 00h not.
// RULE_12 - Secured region entry ends 88@AAA; exit ends 90@AAA then 00.
// RULE_13 - Program: AA, 55, A0@AAA, then data to program address.
// RULE_14 - Bypass entry ends 20@AAA; then A0 plus data programs.
// RULE_15 - Leave bypass by writing 90 then 00 to any address.
// RULE_16 - Erase: AA,55,80,AA,55 then 10@AAA chip or 30@sector.
// RULE_17 - B0 to bank suspends only a running sector erase.
// RULE_18 - Suspended erase allows reads, programs elsewhere and autoselect.
// RULE_19 - 30 to bank resumes only while that bank is suspended.
// RULE_20 - 98@55 enters query only from array read or autoselect.
// RULE_21 - Bank-qualified cycles act on the bank given by the address.
// RULE_22 - During sector erase only suspend is accepted.
// RULE_23 - Suspend completes within 20 microseconds.
// RULE_24 - Mismatched sequence write abandons the sequence.

`default_nettype none

package flash_cmd_pkg;

	localparam int ADDR_W = 21;
	localparam int SECT_LSB = 12;

	// Unlock addresses and command bytes
	localparam logic [11:0] ADDR_UNLOCK1 = 12'haaa;
	localparam logic [11:0] ADDR_UNLOCK2 = 12'h555;
	localparam logic [11:0] ADDR_QUERY = 12'h055;
	localparam logic [7:0] DAT_UNLOCK1 = 8'haa;
	localparam logic [7:0] DAT_UNLOCK2 = 8'h55;
	localparam logic [7:0] DAT_RESET = 8'hf0;
	localparam logic [7:0] DAT_AUTOSEL = 8'h90;
	localparam logic [7:0] DAT_SECURE = 8'h88;
	localparam logic [7:0] DAT_PROGRAM = 8'ha0;
	localparam logic [7:0] DAT_BYPASS = 8'h20;
	localparam logic [7:0] DAT_ERASE = 8'h80;
	localparam logic [7:0] DAT_CHIP = 8'h10;
	localparam logic [7:0] DAT_SECTOR = 8'h30;
	localparam logic [7:0] DAT_SUSPEND = 8'hb0;
	localparam logic [7:0] DAT_QUERY = 8'h98;
	localparam logic [7:0] DAT_ZERO = 8'h00;

	// Autoselect read offsets inside a bank
	localparam logic [11:0] OFS_MAKER = 12'h000;
	localparam logic [11:0] OFS_DEV1 = 12'h002;
	localparam logic [11:0] OFS_DEV2 = 12'h01c;
	localparam logic [11:0] OFS_DEV3 = 12'h01e;
	localparam logic [11:0] OFS_PROT = 12'h004;
	localparam logic [11:0] OFS_LOCK = 12'h006;

	// Strobe timing: setup and hold phase length in clk_sys cycles; the strobe phase runs 3 cycles longer
	localparam int CLK_NS = 25;
	localparam int STROBE_NS = 100;
	localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SUSPEND_US = 20;
	localparam int SUSPEND_CYC = SUSPEND_US * 1000 / CLK_NS;

	// Host command codes
	typedef enum logic [3:0] {
		OP_READ = 4'h0, OP_RESET = 4'h1, OP_AUTOSEL = 4'h2,
		OP_AS_READ = 4'h3, OP_SEC_ENTER = 4'h4, OP_SEC_EXIT = 4'h5,
		OP_PROGRAM = 4'h6, OP_BYP_ENTER = 4'h7, OP_BYP_PROG = 4'h8,
		OP_BYP_EXIT = 4'h9, OP_CHIP_ERASE = 4'ha, OP_SECT_ERASE = 4'hb,
		OP_SUSPEND = 4'hc, OP_RESUME = 4'hd, OP_QUERY = 4'he
	} op_t;

	// One bus cycle on the pins
	typedef struct packed {
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [7:0] data;
	} bus_cyc_t;

	// Command request from the user
	typedef struct packed {
		op_t op;
		logic [ADDR_W-1:0] addr;
		logic [7:0] data;
	} cmd_req_t;

	// Bank mode the host tracks
	typedef enum logic [5:0] {
		MD_READ = 6'b000001, MD_AUTOSEL = 6'b000010, MD_BYPASS = 6'b000100,
		MD_ERASING = 6'b001000, MD_SUSPENDED = 6'b010000,
		MD_QUERY = 6'b100000
	} mode_t;

endpackage

`default_nettype wire

// ===== logic/flash_bus_cycle.sv
// One asynchronous read or write cycle on the flash pins.
// Assumes the flash is the only bus driver while a read is running.
`default_nettype none

module flash_bus_cycle #(
	parameter int PHASE_CYC = flash_cmd_pkg::STROBE_CYC
)(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Cycle request
	input wire logic start,
	input wire flash_cmd_pkg::bus_cyc_t cyc,
	output logic done,
	output logic [7:0] rdData,
	// Flash pins
	output logic chipSel_n,
	output logic wrStrobe_n,
	output logic outEn_n,
	output logic [flash_cmd_pkg::ADDR_W-1:0] addrPin,
	output logic [7:0] dqOut,
	output logic dqOe_n,
	input wire logic [7:0] dqIn
);

	typedef enum logic [3:0] {
		C_IDLE = 4'b0001, C_SETUP = 4'b0010, C_STROBE = 4'b0100,
		C_HOLD = 4'b1000
	} cphase_t;

	cphase_t ph_ff, nxt_ph;
	logic [7:0] cnt_ff, nxt_cnt;
	flash_cmd_pkg::bus_cyc_t cyc_ff, nxt_cyc;
	logic [7:0] rd_ff, nxt_rd;
	logic done_ff, nxt_done;
	// Three-stage sampler for the returned byte from the pins
	logic [7:0] dqS1_ff, dqS2_ff, dqS3_ff;

	// Phase sequencing: address set, then strobe, then release
	always_comb
	begin
		nxt_ph = ph_ff;
		nxt_cnt = cnt_ff;
		nxt_cyc = cyc_ff;
		nxt_rd = rd_ff;
		nxt_done = 1'b0;
		unique case (ph_ff)
			C_IDLE:
			begin
				if (start)
				begin
					nxt_cyc = cyc;
					nxt_ph = C_SETUP;
					nxt_cnt = 8'(PHASE_CYC);
				end
			end
			C_SETUP:
			begin
				nxt_cnt = cnt_ff - 8'h01;
				if (cnt_ff == 8'h01)
				begin
					nxt_ph = C_STROBE;
					nxt_cnt = 8'(PHASE_CYC + 3);
				end
			end
			C_STROBE:
			begin
				nxt_cnt = cnt_ff - 8'h01;
				if (cnt_ff == 8'h01)
				begin
					// Stable once two late sampler stages agree
					if (dqS2_ff == dqS3_ff)
						nxt_rd = dqS3_ff;
					nxt_ph = C_HOLD;
					nxt_cnt = 8'(PHASE_CYC);
				end
			end
			C_HOLD:
			begin
				nxt_cnt = cnt_ff - 8'h01;
				if (cnt_ff == 8'h01)
				begin
					nxt_ph = C_IDLE;
					nxt_done = 1'b1;
				end
			end
			default: nxt_ph = C_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		dqS1_ff <= dqIn;
		dqS2_ff <= dqS1_ff;
		dqS3_ff <= dqS2_ff;
		if (!rst_n)
		begin
			ph_ff <= C_IDLE;
			cnt_ff <= 8'h00;
			cyc_ff <= '0;
			rd_ff <= 8'h00;
			done_ff <= 1'b0;
		end
		else
		begin
			ph_ff <= nxt_ph;
			cnt_ff <= nxt_cnt;
			cyc_ff <= nxt_cyc;
			rd_ff <= nxt_rd;
			done_ff <= nxt_done;
		end
	end

	// Pins: select falls one setup phase before write strobe so the address latch
	// edge is the strobe fall, and both rise together for the data edge
	logic cs_ff, we_ff, oe_ff, doe_ff;
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			cs_ff <= 1'b1;
			we_ff <= 1'b1;
			oe_ff <= 1'b1;
			doe_ff <= 1'b1;
		end
		else
		begin
			cs_ff <= !(nxt_ph == C_SETUP || nxt_ph == C_STROBE);
			we_ff <= !(nxt_ph == C_STROBE && nxt_cyc.wr); // [RULE_01] [RULE_02]
			oe_ff <= !(nxt_ph == C_STROBE && !nxt_cyc.wr); // [RULE_03]
			doe_ff <= !(nxt_ph != C_IDLE && nxt_cyc.wr);
		end
	end

	assign chipSel_n = cs_ff;
	assign wrStrobe_n = we_ff;
	assign outEn_n = oe_ff;
	assign addrPin = cyc_ff.addr;
	assign dqOut = cyc_ff.data;
	assign dqOe_n = doe_ff;
	assign done = done_ff;
	assign rdData = rd_ff;

endmodule // flash_bus_cycle

`default_nettype wire

// ===== logic/flash_cmd_host.sv
// Host-side command sequencer for a byte-mode multi-bank parallel flash.
// Assumes one outstanding command at a time and a flash that needs
// no status polling from this block.
`default_nettype none

module flash_cmd_host #(
	parameter int SUSPEND_WAIT = flash_cmd_pkg::SUSPEND_CYC,
	parameter int PHASE_CYC = flash_cmd_pkg::STROBE_CYC
)(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Command request
	input wire logic reqValid,
	input wire flash_cmd_pkg::cmd_req_t req,
	output logic reqReady,
	// Answer
	output logic rspValid,
	output logic [7:0] rspData,
	output logic rspRefused,
	output flash_cmd_pkg::mode_t bankMode,
	// Flash pins
	output logic chipSel_n,
	output logic wrStrobe_n,
	output logic outEn_n,
	output logic [flash_cmd_pkg::ADDR_W-1:0] addrPin,
	output logic [7:0] dqOut,
	output logic dqOe_n,
	input wire logic [7:0] dqIn
);

	typedef enum logic [4:0] {
		S_IDLE = 5'b00001, S_ISSUE = 5'b00010, S_WAIT = 5'b00100,
		S_SETTLE = 5'b01000, S_DONE = 5'b10000
	} st_t;

	localparam int CW = flash_cmd_pkg::ADDR_W;

	st_t st_ff, nxt_st;
	flash_cmd_pkg::cmd_req_t cmd_ff, nxt_cmd;
	flash_cmd_pkg::mode_t mode_ff, nxt_mode;
	flash_cmd_pkg::mode_t prior_ff, nxt_prior;
	logic [2:0] idx_ff, nxt_idx;
	logic [15:0] wait_ff, nxt_wait;
	logic [7:0] data_ff, nxt_data;
	logic rsp_ff, nxt_rsp, ref_ff, nxt_ref, rdy_ff, nxt_rdy;
	logic cycStart, cycDone;
	logic [7:0] cycRd;
	flash_cmd_pkg::bus_cyc_t cyc;

	// Bank base keeps only sector bits; command offsets fill the rest
	function automatic logic [CW-1:0] inBank(input logic [CW-1:0] a,
		input logic [11:0] ofs);
		inBank = {a[CW-1:flash_cmd_pkg::SECT_LSB], ofs}; // [RULE_21]
	endfunction
	function automatic flash_cmd_pkg::bus_cyc_t wr(input logic [CW-1:0] a,
		input logic [7:0] d);
		wr = '{wr: 1'b1, addr: a, data: d}; // [RULE_04]
	endfunction
	// Sector bits are zero on unqualified cycles except reset and bypass writes, which keep the request address
	function automatic logic [CW-1:0] plain(input logic [11:0] ofs);
		plain = {{(CW-12){1'b0}}, ofs}; // [RULE_05]
	endfunction

	// Bus cycle number idx of the current command
	always_comb
	begin
		cyc = wr(plain(flash_cmd_pkg::ADDR_UNLOCK1),
			flash_cmd_pkg::DAT_UNLOCK1);
		unique case (cmd_ff.op)
			flash_cmd_pkg::OP_READ, flash_cmd_pkg::OP_AS_READ:
				cyc = '{wr: 1'b0, addr: cmd_ff.addr, data: 8'h00}; // [RULE_06] [RULE_09] [RULE_10] [RULE_11]
			flash_cmd_pkg::OP_RESET:
				cyc = wr(cmd_ff.addr, flash_cmd_pkg::DAT_RESET); // [RULE_07]
			flash_cmd_pkg::OP_SUSPEND:
				cyc = wr(cmd_ff.addr, flash_cmd_pkg::DAT_SUSPEND); // [RULE_17]
			flash_cmd_pkg::OP_RESUME:
				cyc = wr(cmd_ff.addr, flash_cmd_pkg::DAT_SECTOR); // [RULE_19]
			flash_cmd_pkg::OP_QUERY:
				cyc = wr(plain(flash_cmd_pkg::ADDR_QUERY),
					flash_cmd_pkg::DAT_QUERY); // [RULE_20]
			flash_cmd_pkg::OP_BYP_PROG:
				cyc = (idx_ff == 3'd0) ?
					wr(cmd_ff.addr, flash_cmd_pkg::DAT_PROGRAM) :
					wr(cmd_ff.addr, cmd_ff.data); // [RULE_14]
			flash_cmd_pkg::OP_BYP_EXIT:
				cyc = (idx_ff == 3'd0) ?
					wr(cmd_ff.addr, flash_cmd_pkg::DAT_AUTOSEL) :
					wr(cmd_ff.addr, flash_cmd_pkg::DAT_ZERO); // [RULE_15]
			default:
			begin
				// Unlocked sequences: AA, 55, then the command cycles
				if (idx_ff == 3'd1 || idx_ff == 3'd4)
					cyc = wr(plain(flash_cmd_pkg::ADDR_UNLOCK2),
						flash_cmd_pkg::DAT_UNLOCK2);
				else if (idx_ff == 3'd3 &&
					cmd_ff.op == flash_cmd_pkg::OP_SEC_EXIT)
					cyc = wr(plain(12'h000), flash_cmd_pkg::DAT_ZERO); // [RULE_12]
				else if (idx_ff == 3'd2)
				begin
					// Default cycle already targets AAA; most only swap data
					unique case (cmd_ff.op)
						flash_cmd_pkg::OP_AUTOSEL:
							cyc = wr(inBank(cmd_ff.addr, flash_cmd_pkg::ADDR_UNLOCK1),
								flash_cmd_pkg::DAT_AUTOSEL); // [RULE_08]
						flash_cmd_pkg::OP_SEC_ENTER:
							cyc.data = flash_cmd_pkg::DAT_SECURE; // [RULE_12]
						flash_cmd_pkg::OP_SEC_EXIT:
							cyc.data = flash_cmd_pkg::DAT_AUTOSEL;
						flash_cmd_pkg::OP_PROGRAM:
							cyc.data = flash_cmd_pkg::DAT_PROGRAM; // [RULE_13]
						flash_cmd_pkg::OP_BYP_ENTER:
							cyc.data = flash_cmd_pkg::DAT_BYPASS; // [RULE_14]
						default:
							cyc.data = flash_cmd_pkg::DAT_ERASE; // [RULE_16]
					endcase
				end
				else if (idx_ff == 3'd5)
					cyc = (cmd_ff.op == flash_cmd_pkg::OP_CHIP_ERASE) ?
						wr(plain(flash_cmd_pkg::ADDR_UNLOCK1),
						flash_cmd_pkg::DAT_CHIP) :
						wr(cmd_ff.addr, flash_cmd_pkg::DAT_SECTOR); // [RULE_16]
			end
		endcase
		if (cmd_ff.op == flash_cmd_pkg::OP_PROGRAM && idx_ff == 3'd3)
			cyc = wr(cmd_ff.addr, cmd_ff.data); // [RULE_13]
	end

	// Sequence length and whether the bank mode lets the command go out
	function automatic logic [2:0] seqLen(input flash_cmd_pkg::op_t o);
		unique case (o)
			flash_cmd_pkg::OP_AUTOSEL, flash_cmd_pkg::OP_SEC_ENTER,
			flash_cmd_pkg::OP_BYP_ENTER: seqLen = 3'd3;
			flash_cmd_pkg::OP_SEC_EXIT, flash_cmd_pkg::OP_PROGRAM: seqLen = 3'd4;
			flash_cmd_pkg::OP_CHIP_ERASE, flash_cmd_pkg::OP_SECT_ERASE:
				seqLen = 3'd6;
			flash_cmd_pkg::OP_BYP_PROG, flash_cmd_pkg::OP_BYP_EXIT: seqLen = 3'd2;
			default: seqLen = 3'd1;
		endcase
	endfunction

	function automatic logic allowed(input flash_cmd_pkg::op_t o,
		input flash_cmd_pkg::mode_t m);
		unique case (m)
			flash_cmd_pkg::MD_ERASING:
				allowed = (o == flash_cmd_pkg::OP_SUSPEND); // [RULE_22]
			flash_cmd_pkg::MD_SUSPENDED:
				allowed = o inside {flash_cmd_pkg::OP_READ, flash_cmd_pkg::OP_PROGRAM,
					flash_cmd_pkg::OP_AUTOSEL, flash_cmd_pkg::OP_RESUME,
					flash_cmd_pkg::OP_RESET}; // [RULE_18] [RULE_19]
			flash_cmd_pkg::MD_BYPASS:
				allowed = o inside {flash_cmd_pkg::OP_READ,
					flash_cmd_pkg::OP_BYP_PROG, flash_cmd_pkg::OP_BYP_EXIT};
			flash_cmd_pkg::MD_AUTOSEL:
				allowed = o inside {flash_cmd_pkg::OP_AS_READ,
					flash_cmd_pkg::OP_RESET, flash_cmd_pkg::OP_QUERY}; // [RULE_07] [RULE_20]
			flash_cmd_pkg::MD_QUERY:
				allowed = (o == flash_cmd_pkg::OP_RESET) ||
					(o == flash_cmd_pkg::OP_READ);
			default:
				allowed = !(o inside {flash_cmd_pkg::OP_SUSPEND,
					flash_cmd_pkg::OP_RESUME, flash_cmd_pkg::OP_BYP_PROG,
					flash_cmd_pkg::OP_BYP_EXIT, flash_cmd_pkg::OP_AS_READ}); // [RULE_14] [RULE_17]
		endcase
	endfunction

	// Command sequencing and bank mode tracking
	always_comb
	begin
		nxt_st = st_ff;
		nxt_cmd = cmd_ff;
		nxt_mode = mode_ff;
		nxt_prior = prior_ff;
		nxt_idx = idx_ff;
		nxt_wait = wait_ff;
		nxt_data = data_ff;
		nxt_rsp = 1'b0;
		nxt_ref = ref_ff;
		nxt_rdy = 1'b0;
		cycStart = 1'b0;
		unique case (st_ff)
			S_IDLE:
			begin
				nxt_rdy = 1'b1;
				if (reqValid && rdy_ff)
				begin
					nxt_rdy = 1'b0;
					nxt_cmd = req;
					nxt_idx = 3'd0;
					nxt_ref = !allowed(req.op, mode_ff); // [RULE_24]
					nxt_st = allowed(req.op, mode_ff) ? S_ISSUE : S_DONE;
				end
			end
			S_ISSUE:
			begin
				cycStart = 1'b1;
				nxt_st = S_WAIT;
			end
			S_WAIT:
			begin
				if (cycDone)
				begin
					nxt_data = cycRd;
					if (idx_ff == seqLen(cmd_ff.op) - 3'd1)
					begin
						nxt_wait = 16'(SUSPEND_WAIT);
						nxt_st = (cmd_ff.op == flash_cmd_pkg::OP_SUSPEND) ?
							S_SETTLE : S_DONE;
					end
					else
					begin
						nxt_idx = idx_ff + 3'd1;
						nxt_st = S_ISSUE;
					end
				end
			end
			S_SETTLE:
			begin
				// Hold off new work until the suspend has taken effect
				nxt_wait = wait_ff - 16'h0001;
				if (wait_ff <= 16'h0001)
					nxt_st = S_DONE; // [RULE_23]
			end
			S_DONE:
			begin
				nxt_rsp = 1'b1;
				nxt_st = S_IDLE;
				if (!ref_ff)
				begin
					unique case (cmd_ff.op)
						flash_cmd_pkg::OP_RESET:
							nxt_mode = (prior_ff == flash_cmd_pkg::MD_SUSPENDED) ?
								flash_cmd_pkg::MD_SUSPENDED : flash_cmd_pkg::MD_READ; // [RULE_07]
						flash_cmd_pkg::OP_AUTOSEL:
						begin
							nxt_prior = mode_ff;
							nxt_mode = flash_cmd_pkg::MD_AUTOSEL; // [RULE_08]
						end
						flash_cmd_pkg::OP_QUERY: nxt_mode = flash_cmd_pkg::MD_QUERY;
						flash_cmd_pkg::OP_BYP_ENTER: nxt_mode = flash_cmd_pkg::MD_BYPASS;
						flash_cmd_pkg::OP_BYP_EXIT: nxt_mode = flash_cmd_pkg::MD_READ; // [RULE_15]
						flash_cmd_pkg::OP_SECT_ERASE:
							nxt_mode = flash_cmd_pkg::MD_ERASING;
						flash_cmd_pkg::OP_SUSPEND:
						begin
							nxt_prior = flash_cmd_pkg::MD_SUSPENDED;
							nxt_mode = flash_cmd_pkg::MD_SUSPENDED;
						end
						flash_cmd_pkg::OP_RESUME:
						begin
							nxt_prior = flash_cmd_pkg::MD_READ;
							nxt_mode = flash_cmd_pkg::MD_ERASING;
						end
						default: nxt_mode = mode_ff;
					endcase
				end
			end
			default: nxt_st = S_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			st_ff <= S_IDLE;
			cmd_ff <= '0;
			mode_ff <= flash_cmd_pkg::MD_READ;
			prior_ff <= flash_cmd_pkg::MD_READ;
			idx_ff <= 3'd0;
			wait_ff <= 16'h0000;
			data_ff <= 8'h00;
			rsp_ff <= 1'b0;
			ref_ff <= 1'b0;
			rdy_ff <= 1'b0;
		end
		else
		begin
			st_ff <= nxt_st;
			cmd_ff <= nxt_cmd;
			mode_ff <= nxt_mode;
			prior_ff <= nxt_prior;
			idx_ff <= nxt_idx;
			wait_ff <= nxt_wait;
			data_ff <= nxt_data;
			rsp_ff <= nxt_rsp;
			ref_ff <= nxt_ref;
			rdy_ff <= nxt_rdy;
		end
	end

	flash_bus_cycle #(.PHASE_CYC(PHASE_CYC)) uCycle (
		.clk_sys(clk_sys), .rst_n(rst_n), .start(cycStart), .cyc(cyc),
		.done(cycDone), .rdData(cycRd), .chipSel_n(chipSel_n),
		.wrStrobe_n(wrStrobe_n), .outEn_n(outEn_n), .addrPin(addrPin),
		.dqOut(dqOut), .dqOe_n(dqOe_n), .dqIn(dqIn)
	);
	assign reqReady = rdy_ff;
	assign rspValid = rsp_ff;
	assign rspData = data_ff;
	assign rspRefused = ref_ff;
	assign bankMode = mode_ff;

endmodule // flash_cmd_host

`default_nettype wire

// ===== test/flash_cmd_host_sva.sv
// Checker for the flash command sequencer, bound onto its top ports.
// Assumes one clk_sys domain and the synchronous active-low reset.
`default_nettype none

module flash_cmd_host_sva #(
	parameter int PHASE_CYC = flash_cmd_pkg::STROBE_CYC
)(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Command side
	input wire logic reqValid,
	input wire flash_cmd_pkg::cmd_req_t req,
	input wire logic reqReady,
	input wire logic rspValid,
	input wire logic rspRefused,
	input wire flash_cmd_pkg::mode_t bankMode,
	// Flash pins
	input wire logic chipSel_n,
	input wire logic wrStrobe_n,
	input wire logic outEn_n,
	input wire logic [flash_cmd_pkg::ADDR_W-1:0] addrPin,
	input wire logic [7:0] dqOut,
	input wire logic dqOe_n
);
	timeunit 1ns;
	timeprecision 100ps;
	logic take, busy;
	logic [7:0] lowCnt_ff, nxt_lowCnt;

	// Count cycles of a held write strobe; a counter beats a long repeat
	always_comb
	begin
		take = reqValid && reqReady;
		busy = bankMode == flash_cmd_pkg::MD_ERASING;
		nxt_lowCnt = wrStrobe_n ? 8'h00 : lowCnt_ff + 8'h01;
	end
	always_ff @(posedge clk_sys)
		lowCnt_ff <= rst_n ? nxt_lowCnt : 8'h00;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// Refusal answer follows the take within three cycles
	sequence refused;
		##[1:3] rspValid && rspRefused;
	endsequence

	chk_pins_hold: assert property (
		!wrStrobe_n && !$past(wrStrobe_n) |-> $stable(addrPin) && $stable(dqOut))
		else $error("pins moved in strobe");
	chk_write_dir: assert property (
		!wrStrobe_n |-> !chipSel_n && !dqOe_n && outEn_n)
		else $error("bad write pins");
	chk_read_dir: assert property (
		!outEn_n |-> dqOe_n && wrStrobe_n && !chipSel_n)
		else $error("bad read pins");
	chk_strobe_len: assert property (
		$rose(wrStrobe_n) |-> lowCnt_ff == PHASE_CYC + 3)
		else $error("strobe width");
	chk_erase_only: assert property (
		take && busy && req.op != flash_cmd_pkg::OP_SUSPEND |-> refused)
		else $error("taken in erase");
	chk_suspend_gate: assert property (
		take && !busy && req.op == flash_cmd_pkg::OP_SUSPEND |-> refused)
		else $error("stray suspend");
	chk_resume_gate: assert property (
		take && bankMode != flash_cmd_pkg::MD_SUSPENDED
		&& req.op == flash_cmd_pkg::OP_RESUME |-> refused)
		else $error("stray resume");
	chk_query_gate: assert property (
		take && req.op == flash_cmd_pkg::OP_QUERY && !(bankMode inside
		{flash_cmd_pkg::MD_READ, flash_cmd_pkg::MD_AUTOSEL}) |-> refused)
		else $error("stray query");
	chk_bypass_gate: assert property (
		take && bankMode != flash_cmd_pkg::MD_BYPASS
		&& req.op == flash_cmd_pkg::OP_BYP_PROG |-> refused)
		else $error("stray bypass");
	chk_suspend_time: assert property (
		take && busy && req.op == flash_cmd_pkg::OP_SUSPEND
		|-> ##[1:1000] bankMode == flash_cmd_pkg::MD_SUSPENDED)
		else $error("suspend late");
	chk_reset_mode: assert property (
		take && bankMode == flash_cmd_pkg::MD_AUTOSEL
		&& req.op == flash_cmd_pkg::OP_RESET
		|-> ##[1:100] bankMode == flash_cmd_pkg::MD_READ)
		else $error("reset mode");

	// Main scenarios reached
	cov_erase: cover property (take && req.op == flash_cmd_pkg::OP_SECT_ERASE);
	cov_susp: cover property (bankMode == flash_cmd_pkg::MD_SUSPENDED);
	cov_asread: cover property (!outEn_n && bankMode == flash_cmd_pkg::MD_AUTOSEL);
endmodule // flash_cmd_host_sva

`default_nettype wire

// ===== test/flash_dev_model.sv
// Pin-level byte-mode flash that logs every write it latches.
// Assumes glitch-free registered strobes from the host.
`default_nettype none

module flash_dev_model #(
	parameter int RD_NS = 70,
	parameter logic [7:0] MAKER_ID = 8'h3c, // Arbitrary value
	parameter logic [7:0] DEV_ID = 8'h6b, // Arbitrary value
	parameter logic [8:0] PROT_SECT = 9'h0c3
)(
	// Flash pins
	input wire logic chipSel_n,
	input wire logic wrStrobe_n,
	input wire logic outEn_n,
	input wire logic [flash_cmd_pkg::ADDR_W-1:0] addrPin,
	input wire logic [7:0] dqOut,
	output logic [7:0] dqIn
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [28:0] wrLog[64];
	int wrCount = 0;
	logic [20:0] aLat = '0;
	logic inWr = 1'b0, asMode = 1'b0;
	logic [7:0] lastRd = 8'h00;
	logic [7:0] rdVal;
	logic [19:0] h1 = '0, h2 = '0;

	// Address taken at the later falling edge of strobe and select
	always @(negedge wrStrobe_n or negedge chipSel_n)
		if (!wrStrobe_n && !chipSel_n)
		begin
			aLat = addrPin;
			inWr = 1'b1;
		end

	// Data taken at the first rising edge; only the low byte decodes
	always @(posedge wrStrobe_n or posedge chipSel_n)
		if (inWr)
		begin
			inWr = 1'b0;
			wrLog[wrCount[5:0]] = {aLat, dqOut};
			wrCount++;
			if (dqOut == 8'hf0 || dqOut == 8'h00)
				asMode = 1'b0;
			else if (h2 == 20'haaaaa && h1 == 20'h55555 && dqOut == 8'h90
				&& aLat[11:0] == 12'haaa)
				asMode = 1'b1;
			h2 = h1;
			h1 = {aLat[11:0], dqOut};
		end

	// Autoselect answers by bank offset; array data is a fixed pattern
	always_comb
		if (!asMode)
			rdVal = addrPin[7:0] ^ 8'h5a;
		else case (addrPin[11:0])
			12'h000: rdVal = MAKER_ID;
			12'h004: rdVal = {7'h0, addrPin[20:12] == PROT_SECT};
			12'h006: rdVal = 8'h80;
			default: rdVal = DEV_ID ^ addrPin[7:0];
		endcase

	// Released bus shows the inverse of the last byte, never a stale copy
	always @(posedge outEn_n)
		lastRd = rdVal;
	assign #(RD_NS) dqIn = (outEn_n || chipSel_n) ? ~lastRd : rdVal;
endmodule // flash_dev_model

`default_nettype wire

// ===== test/flash_cmd_host_test.sv
// Self-checking bench: sequencer against a pin-level flash model.
// Assumes default strobe phase and a shortened suspend wait.
`default_nettype none

module flash_cmd_host_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic reqValid = 1'b0;
	flash_cmd_pkg::cmd_req_t req = '0;
	logic reqReady, rspValid, rspRefused, chipSel_n, wrStrobe_n;
	logic outEn_n, dqOe_n;
	logic [7:0] rspData, dqOut, dqIn;
	logic [20:0] addrPin;
	flash_cmd_pkg::mode_t bankMode;
	int errors = 0;
	int comparisons = 0;
	int base;

	flash_cmd_host #(.SUSPEND_WAIT(4), .PHASE_CYC(4)) dut_u (
		.clk_sys(clk_sys), .rst_n(rst_n), .reqValid(reqValid), .req(req),
		.reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
		.rspRefused(rspRefused), .bankMode(bankMode), .chipSel_n(chipSel_n),
		.wrStrobe_n(wrStrobe_n), .outEn_n(outEn_n), .addrPin(addrPin),
		.dqOut(dqOut), .dqOe_n(dqOe_n), .dqIn(dqIn));
	flash_dev_model dev_u (
		.chipSel_n(chipSel_n), .wrStrobe_n(wrStrobe_n), .outEn_n(outEn_n),
		.addrPin(addrPin), .dqOut(dqOut), .dqIn(dqIn));

	// Clock of 25 ns
	initial
		forever #12.5 clk_sys = ~clk_sys;

	// Compare one result and count it
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Expected write with a fixed address, or with any address
	function logic [29:0] w(input logic [20:0] a, input logic [7:0] d);
		return {1'b0, a, d};
	endfunction
	function logic [29:0] wx(input logic [7:0] d);
		return {1'b1, 21'h0, d};
	endfunction
	function logic [59:0] unl();
		return {w(21'haaa, 8'haa), w(21'h555, 8'h55)};
	endfunction

	// One command, its answer and its writes; first write is leftmost
	task run(input flash_cmd_pkg::op_t op, input logic [20:0] a,
		input logic [7:0] d, input logic rf, input int n, input logic [179:0] s);
		int k;
		logic [29:0] e;
		logic [28:0] g;
		base = dev_u.wrCount;
		for (k = 0; reqReady !== 1'b1 && k < 400; k++)
			@(negedge clk_sys);
		req = '{op: op, addr: a, data: d};
		reqValid = 1'b1;
		@(negedge clk_sys);
		reqValid = 1'b0;
		for (k = 0; rspValid !== 1'b1 && k < 400; k++)
			@(negedge clk_sys);
		cmp(rspValid, 1'b1);
		cmp(rspRefused, rf);
		cmp(dev_u.wrCount - base, n);
		for (int i = 0; i < n; i++)
		begin
			e = s[(n - 1 - i) * 30 +: 30];
			g = dev_u.wrLog[base + i];
			cmp(e[29] ? {1'b1, 21'h0, g[7:0]} : {1'b0, g}, e);
		end
	endtask

	// Pulse the reset pin
	task pin_reset(input int n);
		@(negedge clk_sys);
		rst_n = 1'b0;
		repeat (n) @(negedge clk_sys);
		rst_n = 1'b1;
	endtask

	task t_read_query();
		run(flash_cmd_pkg::OP_READ, 21'h012345, '0, 0, 0, '0);
		cmp(rspData, 8'h45 ^ 8'h5a);
		run(flash_cmd_pkg::OP_AS_READ, '0, '0, 1, 0, '0);
		run(flash_cmd_pkg::OP_QUERY, '0, '0, 0, 1, w(21'h55, 8'h98));
		cmp(bankMode, flash_cmd_pkg::MD_QUERY);
		run(flash_cmd_pkg::OP_QUERY, '0, '0, 1, 0, '0);
		run(flash_cmd_pkg::OP_RESET, '0, '0, 0, 1, wx(8'hf0));
		$display("test read_query done");
	endtask

	task t_autosel();
		run(flash_cmd_pkg::OP_AUTOSEL, 21'h0c3000, 8'h00, 0, 3,
			{unl(), w(21'h0c3aaa, 8'h90)});
		cmp(bankMode, flash_cmd_pkg::MD_AUTOSEL);
		run(flash_cmd_pkg::OP_AS_READ, 21'h0c3006, 8'h00, 0, 0, '0);
		cmp(rspData, 8'h80);
		run(flash_cmd_pkg::OP_AS_READ, 21'h0c3004, 8'h00, 0, 0, '0);
		cmp(rspData, 8'h01);
		run(flash_cmd_pkg::OP_AS_READ, 21'h0c301c, 8'h00, 0, 0, '0);
		cmp(rspData, 8'h6b ^ 8'h1c);
		run(flash_cmd_pkg::OP_RESET, 21'h0, 8'h00, 0, 1, wx(8'hf0));
		cmp(bankMode, flash_cmd_pkg::MD_READ);
		$display("test autoselect done");
	endtask

	task t_prog_secure();
		run(flash_cmd_pkg::OP_PROGRAM, 21'h1a0123, 8'h3c, 0, 4, {unl(),
			w(21'haaa, 8'ha0), w(21'h1a0123, 8'h3c)});
		run(flash_cmd_pkg::OP_SEC_ENTER, 21'h0, 8'h00, 0, 3,
			{unl(), w(21'haaa, 8'h88)});
		run(flash_cmd_pkg::OP_SEC_EXIT, 21'h0, 8'h00, 0, 4,
			{unl(), w(21'haaa, 8'h90), wx(8'h00)});
		$display("test program_secure done");
	endtask

	task t_bypass();
		run(flash_cmd_pkg::OP_BYP_PROG, 21'h0, 8'h00, 1, 0, '0);
		run(flash_cmd_pkg::OP_BYP_ENTER, 21'h0, 8'h00, 0, 3,
			{unl(), w(21'haaa, 8'h20)});
		cmp(bankMode, flash_cmd_pkg::MD_BYPASS);
		run(flash_cmd_pkg::OP_BYP_PROG, 21'h0450ff, 8'h96, 0, 2,
			{wx(8'ha0), w(21'h0450ff, 8'h96)});
		run(flash_cmd_pkg::OP_BYP_EXIT, 21'h0, 8'h00, 0, 2,
			{wx(8'h90), wx(8'h00)});
		cmp(bankMode, flash_cmd_pkg::MD_READ);
		$display("test bypass done");
	endtask

	task t_erase();
		run(flash_cmd_pkg::OP_SUSPEND, 21'h0c3000, '0, 1, 0, '0);
		run(flash_cmd_pkg::OP_RESUME, 21'h0c3000, '0, 1, 0, '0);
		run(flash_cmd_pkg::OP_SECT_ERASE, 21'h0c3000, 8'h00, 0, 6, {unl(),
			w(21'haaa, 8'h80), unl(), w(21'h0c3000, 8'h30)});
		run(flash_cmd_pkg::OP_PROGRAM, 21'h0, 8'h11, 1, 0, '0);
		run(flash_cmd_pkg::OP_SUSPEND, 21'h0c3000, 8'h00, 0, 1,
			w(21'h0c3000, 8'hb0));
		cmp(bankMode, flash_cmd_pkg::MD_SUSPENDED);
		run(flash_cmd_pkg::OP_READ, 21'h000010, 8'h00, 0, 0, '0);
		cmp(rspData, 8'h10 ^ 8'h5a);
		run(flash_cmd_pkg::OP_RESUME, 21'h0c3000, 8'h00, 0, 1,
			w(21'h0c3000, 8'h30));
		cmp(bankMode, flash_cmd_pkg::MD_ERASING);
		pin_reset(2);
		cmp(bankMode, flash_cmd_pkg::MD_READ);
		run(flash_cmd_pkg::OP_CHIP_ERASE, 21'h0, 8'h00, 0, 6, {unl(),
			w(21'haaa, 8'h80), unl(), w(21'haaa, 8'h10)});
		pin_reset(2);
		$display("test erase done");
	endtask

	// Verdict and end of run
	task wrap_up();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		repeat (8) @(negedge clk_sys);
		rst_n = 1'b1;
		t_read_query();
		t_autosel();
		t_prog_secure();
		t_bypass();
		t_erase();
		wrap_up();
	end

	// Watchdog well beyond the expected run of under a thousand cycles
	initial
	begin
		#500us;
		errors++;
		$display("watchdog expired");
		wrap_up();
	end
endmodule // flash_cmd_host_test

bind flash_cmd_host flash_cmd_host_sva #(.PHASE_CYC(PHASE_CYC)) chk_u (
	.clk_sys(clk_sys), .rst_n(rst_n), .reqValid(reqValid), .req(req),
	.reqReady(reqReady), .rspValid(rspValid),
	.rspRefused(rspRefused), .bankMode(bankMode), .chipSel_n(chipSel_n),
	.wrStrobe_n(wrStrobe_n), .outEn_n(outEn_n), .addrPin(addrPin),
	.dqOut(dqOut), .dqOe_n(dqOe_n));

`default_nettype wire
